// file: hdl/long_exec_datapath.sv
// execution datapath for rotate, subtract, decrement-skip and set ops
`timescale 1ns/1ps
`default_nettype none
module long_exec_datapath
  import exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire exec_pkg::op_type op_code,
  input wire logic [2:0] bit_select,
  input wire logic [exec_pkg::DATA_W-1:0] mem_rdata,
  output logic op_ready,
  output logic [exec_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_we,
  output logic [exec_pkg::DATA_W-1:0] acc,
  output logic [exec_pkg::FLAG_W-1:0] flags,
  output logic skip_next,
  output logic dummy_cycle
);
  import exec_pkg::*;

  logic [DATA_W-1:0] acc_ff, nxt_acc;
  logic [FLAG_W-1:0] flags_ff, nxt_flags;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic we_ff, nxt_we;
  logic skip_ff, nxt_skip;
  cycle_state_type state_ff, nxt_state;

  logic [DATA_W-1:0] diff;
  logic [FLAG_W-1:0] sub_flags;
  // mem_rdata is only trusted in the cycle an op is presented
  wire logic take = op_valid && (state_ff == st_run_type);
  wire logic [DATA_W-1:0] rot_val =
    {flags_ff[F_C], mem_rdata[MSB:1]};
  wire logic [DATA_W-1:0] dec_val = mem_rdata - ONE;
  wire logic dec_zero = (dec_val == ZERO);
  wire logic [DATA_W-1:0] bit_mask = ONE << bit_select;
  wire logic [DATA_W-1:0] setbit_val = mem_rdata | bit_mask;

  sub_borrow_unit u_sub (
    .minuend(acc_ff),
    .subtrahend(mem_rdata),
    .carry_in(flags_ff[F_C]),
    .flags_in(flags_ff),
    .difference(diff),
    .flags_out(sub_flags)
  );

  // every op_type code is legal, so the case needs no default
  always_comb begin
    nxt_acc = acc_ff;
    nxt_flags = flags_ff;
    nxt_wdata = wdata_ff;
    nxt_we = 1'b0;
    nxt_skip = 1'b0;
    nxt_state = st_run_type;
    if (take) begin
      unique case (op_code)
        op_idle_type: begin
        end
        op_rotate_right_carry_to_acc_type: begin
          nxt_acc = rot_val;
          nxt_flags[F_C] = mem_rdata[0];
        end
        op_subtract_borrow_to_acc_type: begin
          nxt_acc = diff;
          nxt_flags = sub_flags;
        end
        op_subtract_borrow_to_mem_type: begin
          nxt_wdata = diff;
          nxt_we = 1'b1;
          nxt_flags = sub_flags;
        end
        op_decrement_skip_if_zero_type: begin
          nxt_wdata = dec_val;
          nxt_we = 1'b1;
          nxt_skip = dec_zero;
          nxt_state = st_dummy_type;
        end
        op_decrement_to_acc_skip_if_zero_type: begin
          nxt_acc = dec_val;
          nxt_skip = dec_zero;
          nxt_state = st_dummy_type;
        end
        op_set_memory_byte_type: begin
          nxt_wdata = ALL_ONES;
          nxt_we = 1'b1;
        end
        op_set_memory_bit_type: begin
          nxt_wdata = setbit_val;
          nxt_we = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_ff <= ACC_RESET;
      flags_ff <= FLAG_RESET;
      wdata_ff <= ZERO;
      we_ff <= 1'b0;
      skip_ff <= 1'b0;
      state_ff <= st_run_type;
    end else begin
      acc_ff <= nxt_acc;
      flags_ff <= nxt_flags;
      wdata_ff <= nxt_wdata;
      we_ff <= nxt_we;
      skip_ff <= nxt_skip;
      state_ff <= nxt_state;
    end
  end

  // second cycle of a decrement-skip refuses new ops
  assign op_ready = (state_ff == st_run_type);
  assign dummy_cycle = (state_ff == st_dummy_type);
  assign acc = acc_ff;
  assign flags = flags_ff;
  assign mem_wdata = wdata_ff;
  assign mem_we = we_ff;
  assign skip_next = skip_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  rotate_result_a: assert property (take &&
    op_code == op_rotate_right_carry_to_acc_type |=>
    acc_ff == {$past(flags_ff[F_C]), $past(mem_rdata[MSB:1])} &&
    flags_ff[F_C] == $past(mem_rdata[0]))
    else $error("rotate result wrong");
  rotate_side_a: assert property (take &&
    op_code == op_rotate_right_carry_to_acc_type |=>
    !mem_we && flags_ff[FLAG_W-1:1] == $past(flags_ff[FLAG_W-1:1]))
    else $error("rotate touched memory or flags");
  sub_acc_a: assert property (take &&
    op_code == op_subtract_borrow_to_acc_type |=>
    !mem_we && acc_ff == DATA_W'($past(acc_ff) - $past(mem_rdata)
    - DATA_W'(!$past(flags_ff[F_C]))))
    else $error("subtract to acc wrong");
  sub_mem_a: assert property (take &&
    op_code == op_subtract_borrow_to_mem_type |=>
    mem_we && acc_ff == $past(acc_ff) &&
    mem_wdata == DATA_W'($past(acc_ff) - $past(mem_rdata)
    - DATA_W'(!$past(flags_ff[F_C]))))
    else $error("subtract to memory wrong");
  sub_carry_a: assert property (take &&
    (op_code == op_subtract_borrow_to_acc_type ||
     op_code == op_subtract_borrow_to_mem_type) |=>
    flags_ff[F_C] == ({1'b0, $past(acc_ff)} >=
    {1'b0, $past(mem_rdata)} + 9'(!$past(flags_ff[F_C]))))
    else $error("subtract carry wrong");
  dec_mem_a: assert property (take &&
    op_code == op_decrement_skip_if_zero_type |=>
    mem_we && mem_wdata == DATA_W'($past(mem_rdata) - ONE) &&
    skip_next == ($past(mem_rdata) == ONE))
    else $error("decrement to memory wrong");
  dec_acc_a: assert property (take &&
    op_code == op_decrement_to_acc_skip_if_zero_type |=>
    !mem_we && acc_ff == DATA_W'($past(mem_rdata) - ONE) &&
    skip_next == (acc_ff == ZERO))
    else $error("decrement to acc wrong");
  dec_cycles_a: assert property (take &&
    (op_code == op_decrement_skip_if_zero_type ||
     op_code == op_decrement_to_acc_skip_if_zero_type) |=>
    dummy_cycle && !op_ready && flags_ff == $past(flags_ff)
    ##1 op_ready)
    else $error("decrement cycle count or flags wrong");
  set_byte_a: assert property (take &&
    op_code == op_set_memory_byte_type |=>
    mem_we && mem_wdata == ALL_ONES && flags_ff == $past(flags_ff))
    else $error("set byte wrong");
  set_bit_a: assert property (take &&
    op_code == op_set_memory_bit_type |=>
    mem_we && mem_wdata == ($past(mem_rdata) | (ONE << $past(bit_select))))
    else $error("set bit wrong");
  // zero and half carry checks rebuild the result from the operands; the CZ check reuses the registered Z flag
  sub_zero_a: assert property (take &&
    (op_code == op_subtract_borrow_to_acc_type ||
     op_code == op_subtract_borrow_to_mem_type) |=>
    flags_ff[F_Z] == (DATA_W'($past(acc_ff) - $past(mem_rdata)
    - DATA_W'(!$past(flags_ff[F_C]))) == ZERO))
    else $error("subtract zero flag wrong");
  sub_ac_a: assert property (take &&
    (op_code == op_subtract_borrow_to_acc_type ||
     op_code == op_subtract_borrow_to_mem_type) |=>
    flags_ff[F_AC] == ({1'b0, $past(acc_ff[NIB_MSB:0])} >=
    {1'b0, $past(mem_rdata[NIB_MSB:0])} + 5'(!$past(flags_ff[F_C]))))
    else $error("subtract half carry wrong");
  sub_cz_a: assert property (take &&
    (op_code == op_subtract_borrow_to_acc_type ||
     op_code == op_subtract_borrow_to_mem_type) |=>
    flags_ff[F_CZ] == (flags_ff[F_Z] && $past(flags_ff[F_Z])))
    else $error("subtract chained zero wrong");
  dummy_quiet_a: assert property (dummy_cycle |=>
    !mem_we && !skip_next && acc_ff == $past(acc_ff))
    else $error("dummy cycle not quiet");

  sub_neg_c: cover property (take &&
    op_code == op_subtract_borrow_to_acc_type ##1 !flags_ff[F_C]);
  dec_skip_c: cover property (take &&
    op_code == op_decrement_skip_if_zero_type ##1 skip_next);
  rot_c: cover property (take && op_code == op_rotate_right_carry_to_acc_type);
  set_bit_c: cover property (take && op_code == op_set_memory_bit_type);
  dec_wrap_c: cover property (take && mem_rdata == ZERO &&
    op_code == op_decrement_to_acc_skip_if_zero_type);
endmodule
`default_nettype wire

// file: shared/exec_pkg.sv
// shared constants and opcode set of the extended execution datapath
package exec_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;
  localparam int MSB = 7;
  localparam int NIB_MSB = 3;
  // flag vector positions
  localparam int F_C = 0;
  localparam int F_AC = 1;
  localparam int F_Z = 2;
  localparam int F_OV = 3;
  localparam int F_SC = 4;
  localparam int F_CZ = 5;
  localparam int FLAG_W = 6;
  localparam logic [5:0] FLAG_RESET = 6'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;

  typedef enum logic [2:0] {
    op_idle_type                          = 3'b000,
    op_rotate_right_carry_to_acc_type     = 3'b001,
    op_subtract_borrow_to_acc_type        = 3'b010,
    op_subtract_borrow_to_mem_type        = 3'b011,
    op_decrement_skip_if_zero_type        = 3'b100,
    op_decrement_to_acc_skip_if_zero_type = 3'b101,
    op_set_memory_byte_type               = 3'b110,
    op_set_memory_bit_type                = 3'b111
  } op_type;

  typedef enum logic [0:0] {
    st_run_type   = 1'b0,
    st_dummy_type = 1'b1
  } cycle_state_type;
endpackage

// file: hdl/sub_borrow_unit.sv
// 8-bit subtract-with-borrow unit with flag outputs
`timescale 1ns/1ps
`default_nettype none
module sub_borrow_unit
  import exec_pkg::*;
(
  input wire logic [exec_pkg::DATA_W-1:0] minuend,
  input wire logic [exec_pkg::DATA_W-1:0] subtrahend,
  input wire logic carry_in,
  input wire logic [exec_pkg::FLAG_W-1:0] flags_in,
  output logic [exec_pkg::DATA_W-1:0] difference,
  output logic [exec_pkg::FLAG_W-1:0] flags_out
);
  import exec_pkg::*;

  logic [DATA_W:0] full_diff;
  logic [NIB_MSB+1:0] low_diff;
  logic borrow;
  logic ov;
  logic z;

  assign borrow = ~carry_in;
  // extra bit catches the borrow out of bit 7; wraps mod 256
  assign full_diff = {1'b0, minuend} - {1'b0, subtrahend}
                     - 9'(borrow);
  assign low_diff = {1'b0, minuend[NIB_MSB:0]} - {1'b0, subtrahend[NIB_MSB:0]}
                    - 5'(borrow);
  assign difference = full_diff[DATA_W-1:0];
  assign ov = (minuend[MSB] ^ subtrahend[MSB])
              & (minuend[MSB] ^ difference[MSB]);
  assign z = (difference == ZERO);

  // compare flags: cz chains zero through the incoming zero flag
  always_comb begin
    flags_out = flags_in;
    flags_out[F_C] = ~full_diff[DATA_W];
    flags_out[F_AC] = ~low_diff[NIB_MSB+1];
    flags_out[F_Z] = z;
    flags_out[F_OV] = ov;
    flags_out[F_SC] = difference[MSB] ^ ov;
    flags_out[F_CZ] = z & flags_in[F_Z];
  end
endmodule
`default_nettype wire

// file: tb/test_long_exec_datapath.sv
// self-checking bench for the extended execution datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module test_long_exec_datapath;
  import exec_pkg::*;
  typedef struct {
    op_type op;
    logic [7:0] m;
    logic [2:0] b;
    logic [7:0] a;
    logic we;
    logic [7:0] wd;
    logic c;
    logic sk;
    logic [5:0] f;
  } row_type;
  logic ref_clk = 1'b0;
  logic resetn;
  logic op_valid;
  op_type op_code;
  logic [2:0] bit_select;
  logic [7:0] mem_rdata;
  logic op_ready;
  logic [7:0] mem_wdata;
  logic mem_we;
  logic [7:0] acc;
  logic [5:0] flags;
  logic skip_next;
  logic dummy_cycle;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  // rows run in order: each expectation builds on the acc and carry before it
  // f is the whole flag vector: [5]CZ [4]SC [3]OV [2]Z [1]AC [0]C
  row_type rows [18] = '{
    '{op_type'(3'h2), 8'h00, 3'h0, 8'hFF, 1'b0, 8'h00, 1'b0, 1'b0, 6'h10},
    '{op_type'(3'h2), 8'h0F, 3'h0, 8'hEF, 1'b0, 8'h00, 1'b1, 1'b0, 6'h11},
    '{op_type'(3'h2), 8'h0F, 3'h0, 8'hE0, 1'b0, 8'h00, 1'b1, 1'b0, 6'h13},
    '{op_type'(3'h3), 8'hE0, 3'h0, 8'hE0, 1'b1, 8'h00, 1'b1, 1'b0, 6'h07},
    '{op_type'(3'h1), 8'h03, 3'h0, 8'h81, 1'b0, 8'h00, 1'b1, 1'b0, 6'h07},
    '{op_type'(3'h1), 8'h02, 3'h0, 8'h81, 1'b0, 8'h00, 1'b0, 1'b0, 6'h06},
    '{op_type'(3'h1), 8'hFF, 3'h0, 8'h7F, 1'b0, 8'h00, 1'b1, 1'b0, 6'h07},
    '{op_type'(3'h3), 8'h80, 3'h0, 8'h7F, 1'b1, 8'hFF, 1'b0, 1'b0, 6'h0A},
    '{op_type'(3'h6), 8'h12, 3'h0, 8'h7F, 1'b1, 8'hFF, 1'b0, 1'b0, 6'h0A},
    '{op_type'(3'h7), 8'hFE, 3'h0, 8'h7F, 1'b1, 8'hFF, 1'b0, 1'b0, 6'h0A},
    '{op_type'(3'h7), 8'h00, 3'h7, 8'h7F, 1'b1, 8'h80, 1'b0, 1'b0, 6'h0A},
    '{op_type'(3'h7), 8'hA5, 3'h3, 8'h7F, 1'b1, 8'hAD, 1'b0, 1'b0, 6'h0A},
    '{op_type'(3'h3), 8'h7E, 3'h0, 8'h7F, 1'b1, 8'h00, 1'b1, 1'b0, 6'h07},
    '{op_type'(3'h3), 8'h7F, 3'h0, 8'h7F, 1'b1, 8'h00, 1'b1, 1'b0, 6'h27},
    '{op_type'(3'h4), 8'h01, 3'h0, 8'h7F, 1'b1, 8'h00, 1'b1, 1'b1, 6'h27},
    '{op_type'(3'h4), 8'h00, 3'h0, 8'h7F, 1'b1, 8'hFF, 1'b1, 1'b0, 6'h27},
    '{op_type'(3'h5), 8'h01, 3'h0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 6'h27},
    '{op_type'(3'h5), 8'h00, 3'h0, 8'hFF, 1'b0, 8'h00, 1'b1, 1'b0, 6'h27}
  };

  long_exec_datapath uut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .op_valid(op_valid),
    .op_code(op_code),
    .bit_select(bit_select),
    .mem_rdata(mem_rdata),
    .op_ready(op_ready),
    .mem_wdata(mem_wdata),
    .mem_we(mem_we),
    .acc(acc),
    .flags(flags),
    .skip_next(skip_next),
    .dummy_cycle(dummy_cycle)
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic final_report;
    $display("mismatches %0d of %0d comparisons", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // request held through a dummy cycle, so a refused edge is exercised too
  task automatic do_op(input row_type r);
    logic [5:0] pf;
    logic z;
    op_valid = 1'b1;
    op_code = r.op;
    bit_select = r.b;
    mem_rdata = r.m;
    while (op_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      `CHK("refused write", mem_we, 1'b0)
    end
    pf = flags;
    @(posedge ref_clk);
    #1;
    z = ((r.op == op_subtract_borrow_to_mem_type) ? r.wd : r.a) == 8'h00;
    `CHK("acc", acc, r.a)
    `CHK("write", mem_we, r.we)
    if (r.we) `CHK("wdata", mem_wdata, r.wd)
    `CHK("skip", skip_next, r.sk)
    `CHK("carry", flags[F_C], r.c)
    `CHK("flags all", flags, r.f)
    if (r.op[2:1] == 2'b01) begin
      `CHK("zero", flags[F_Z], z)
    end else begin
      `CHK("flags", flags[5:1], pf[5:1])
    end
    if (r.op[2:1] == 2'b10) begin
      `CHK("dummy", {dummy_cycle, op_ready}, 2'b10)
    end
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    resetn = 1'b0;
    op_valid = 1'b0;
    op_code = op_idle_type;
    bit_select = 3'h0;
    mem_rdata = 8'h00;
    repeat (10) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    `CHK("reset state", {acc, flags, mem_we, op_ready}, 16'h0001)
    foreach (rows[i]) do_op(rows[i]);
    op_valid = 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("idle after dummy", {op_ready, mem_we, dummy_cycle}, 3'b100)
    // second reset in mid-run clears the accumulator at once
    resetn = 1'b0;
    #1;
    `CHK("mid reset", {acc, flags, skip_next}, 15'h0000)
    final_report();
  end
endmodule
`default_nettype wire
